// File: pldpr_defines.svh
`ifndef PLDPR_DEFINES_SVH
`define PLDPR_DEFINES_SVH

// register offsets on the configuration port
`define PLDPR_OFS_PWR_CFG     8'h90
`define PLDPR_OFS_TWO_PH      8'h96
`define PLDPR_OFS_THREE_PH    8'h98

// reset values
`define PLDPR_RST_PWR_CFG     32'h0000_0000
`define PLDPR_RST_TWO_PH      32'h0000_0000
`define PLDPR_RST_THREE_PH    32'h0000_0000

// field positions of the power configuration register
`define PLDPR_PARITY_BIT      31
`define PLDPR_SPEED_MSB       30
`define PLDPR_SPEED_LSB       15
`define PLDPR_DEADBAND_BIT    14
`define PLDPR_POWER_MSB       13
`define PLDPR_POWER_LSB       4
`define PLDPR_HYST_MSB        3
`define PLDPR_HYST_LSB        2
`define PLDPR_MODE_MSB        1
`define PLDPR_MODE_LSB        0

// field positions of the two-phase profile register
`define PLDPR_STEP0_MSB       30
`define PLDPR_STEP_WIDTH      3
`define PLDPR_STEP_COUNT      8
`define PLDPR_SPARE_MSB       6

// speed code is hertz times 16, power code is watts times 4
`define PLDPR_SPEED_FRAC_BITS 4
`define PLDPR_POWER_FRAC_BITS 2

// duty per step code, in units of 0.25 percent
`define PLDPR_DUTY_0          10'h000
`define PLDPR_DUTY_1          10'h0c8
`define PLDPR_DUTY_2          10'h12c
`define PLDPR_DUTY_3          10'h14f
`define PLDPR_DUTY_4          10'h15e
`define PLDPR_DUTY_5          10'h177
`define PLDPR_DUTY_6          10'h186
`define PLDPR_DUTY_7          10'h18c

// hysteresis per select code, in units of 0.5 percent
`define PLDPR_HYST_0          5'h0a
`define PLDPR_HYST_1          5'h0f
`define PLDPR_HYST_2          5'h14
`define PLDPR_HYST_3          5'h19

`endif

// File: pldpr_pkg.sv
package pldpr_pkg;

    // input power regulation mode
    typedef enum logic [1:0] {
        PLDPR_MODE_OFF    = 2'b00,
        PLDPR_MODE_CLOSED = 2'b01,
        PLDPR_MODE_LIMIT  = 2'b10,
        PLDPR_MODE_RSVD   = 2'b11
    } pldpr_mode_t;

    // power configuration register layout
    typedef struct packed {
        logic        parity;
        logic [15:0] max_speed;
        logic        dead_band_correction_on;
        logic [9:0]  max_power;
        logic [1:0]  regulation_hysteresis_sel;
        pldpr_mode_t mode;
    } pldpr_pwr_cfg_t;

    // two-phase profile register layout, step 0 in the top field
    typedef struct packed {
        logic             parity;
        logic [0:7][2:0]  step;
        logic [6:0]       spare;
    } pldpr_two_ph_t;

    // register access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } pldpr_req_t;

    // register read answer
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } pldpr_rsp_t;

    // decoded duty of all steps, 0.25 percent units
    typedef logic [0:7][9:0] pldpr_duty_vec_t;

endpackage : pldpr_pkg

// File: pldpr_reg_cell.sv
`timescale 1ns/1ps
`include "pldpr_defines.svh"

module pldpr_reg_cell #(
    parameter logic [7:0]  OFFSET    = 8'h00,
    parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    input  wire pldpr_pkg::pldpr_req_t req_i,
    output logic [31:0]            value_o
);
    import pldpr_pkg::*;

    typedef struct packed {
        logic [31:0] value;
    } pldpr_cell_state_t;

    pldpr_cell_state_t state;
    pldpr_cell_state_t next_state;

    // full-word write on address match, all bits stored as written
    always_comb begin
        next_state = state;
        if (req_i.wr && (req_i.addr == OFFSET)) begin
            next_state.value = req_i.wdata;
        end
    end

    // state register, every bit resets to its documented value
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state.value <= RESET_VAL;
        end else begin
            state <= next_state;
        end
    end

    assign value_o = state.value;

endmodule : pldpr_reg_cell

// File: pldpr_regs.sv
`timescale 1ns/1ps
`include "pldpr_defines.svh"

module pldpr_regs (
    input  wire logic                    mclk_i,
    input  wire logic                    rstn_i,
    input  wire pldpr_pkg::pldpr_req_t   req_i,
    output pldpr_pkg::pldpr_rsp_t        rsp_o,
    output logic [15:0]                  max_speed_code_o,
    output logic [11:0]                  max_speed_hz_o,
    output logic                         dead_band_correction_on_o,
    output logic [9:0]                   max_power_code_o,
    output logic [7:0]                   max_power_w_o,
    output logic [1:0]                   regulation_hysteresis_sel_o,
    output logic [4:0]                   hysteresis_half_pct_o,
    output pldpr_pkg::pldpr_mode_t       regulation_mode_o,
    output logic                         closed_loop_power_o,
    output logic                         power_limit_o,
    output logic [2:0]                   two_phase_step_duty_first_o,
    output logic [2:0]                   two_phase_step_duty_last_o,
    output pldpr_pkg::pldpr_duty_vec_t   two_phase_duty_o,
    output logic [31:0]                  three_phase_profile_o
);
    import pldpr_pkg::*;

    // read answer plus the decoded settings, so every data output leaves a flip-flop
    typedef struct packed {
        pldpr_rsp_t      rsp;
        logic [4:0]      hyst_half_pct;
        logic            closed_loop;
        logic            power_limit;
        pldpr_duty_vec_t duty;
    } pldpr_top_state_t;

    // state, raw register words and write-side views
    pldpr_top_state_t state;
    pldpr_top_state_t next_state;
    logic [31:0]      pwr_word;
    logic [31:0]      two_word;
    logic [31:0]      three_word;
    pldpr_pwr_cfg_t   pwr_cfg;
    pldpr_two_ph_t    two_ph;
    pldpr_pwr_cfg_t   wr_cfg;     // write data seen as a power configuration word
    pldpr_two_ph_t    wr_two;     // write data seen as a two-phase profile word
    logic             wr_cfg_hit; // this edge writes the power configuration
    logic             wr_two_hit; // this edge writes the two-phase profile

    // step code to duty in 0.25 percent units
    function automatic logic [9:0] pldpr_duty_of(input logic [2:0] code);
        logic [9:0] duty;
        duty = `PLDPR_DUTY_0;
        case (code)
            3'h0:    duty = `PLDPR_DUTY_0;
            3'h1:    duty = `PLDPR_DUTY_1;
            3'h2:    duty = `PLDPR_DUTY_2;
            3'h3:    duty = `PLDPR_DUTY_3;
            3'h4:    duty = `PLDPR_DUTY_4;
            3'h5:    duty = `PLDPR_DUTY_5;
            3'h6:    duty = `PLDPR_DUTY_6;
            3'h7:    duty = `PLDPR_DUTY_7;
            default: duty = `PLDPR_DUTY_0;
        endcase
        return duty;
    endfunction : pldpr_duty_of

    // hysteresis select to band width in 0.5 percent units
    function automatic logic [4:0] pldpr_hyst_of(input logic [1:0] sel);
        logic [4:0] band;
        band = `PLDPR_HYST_0;
        case (sel)
            2'h0:    band = `PLDPR_HYST_0;
            2'h1:    band = `PLDPR_HYST_1;
            2'h2:    band = `PLDPR_HYST_2;
            2'h3:    band = `PLDPR_HYST_3;
            default: band = `PLDPR_HYST_0;
        endcase
        return band;
    endfunction : pldpr_hyst_of

    // power configuration storage
    pldpr_reg_cell #(
        .OFFSET    (`PLDPR_OFS_PWR_CFG),
        .RESET_VAL (`PLDPR_RST_PWR_CFG)
    ) u_pwr_cfg (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .req_i   (req_i),
        .value_o (pwr_word)
    );

    // two-phase profile storage
    pldpr_reg_cell #(
        .OFFSET    (`PLDPR_OFS_TWO_PH),
        .RESET_VAL (`PLDPR_RST_TWO_PH)
    ) u_two_ph (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .req_i   (req_i),
        .value_o (two_word)
    );

    // three-phase profile storage, fields handled by the consumer
    pldpr_reg_cell #(
        .OFFSET    (`PLDPR_OFS_THREE_PH),
        .RESET_VAL (`PLDPR_RST_THREE_PH)
    ) u_three_ph (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .req_i   (req_i),
        .value_o (three_word)
    );

    // raw words seen as their field layouts
    assign pwr_cfg = pldpr_pwr_cfg_t'(pwr_word);
    assign two_ph  = pldpr_two_ph_t'(two_word);

    // write strobes for the power configuration and two-phase registers, same address match as the storage cells
    assign wr_cfg     = pldpr_pwr_cfg_t'(req_i.wdata);
    assign wr_two     = pldpr_two_ph_t'(req_i.wdata);
    assign wr_cfg_hit = req_i.wr && (req_i.addr == `PLDPR_OFS_PWR_CFG);
    assign wr_two_hit = req_i.wr && (req_i.addr == `PLDPR_OFS_TWO_PH);

    // read mux, one cycle answer, unmapped offsets read zero
    always_comb begin
        next_state           = state;
        next_state.rsp.valid = req_i.rd;
        next_state.rsp.data  = 32'h0000_0000;
        if (req_i.rd) begin
            case (req_i.addr)
                `PLDPR_OFS_PWR_CFG:  next_state.rsp.data = pwr_word;
                `PLDPR_OFS_TWO_PH:   next_state.rsp.data = two_word;
                `PLDPR_OFS_THREE_PH: next_state.rsp.data = three_word;
                default:             next_state.rsp.data = 32'h0000_0000;
            endcase
        end
        // decode the written word on the edge that stores it, so decoded
        // outputs change in the same cycle as the raw fields
        if (wr_cfg_hit) begin
            // hysteresis band of the new select
            next_state.hyst_half_pct = pldpr_hyst_of(wr_cfg.regulation_hysteresis_sel);
            // mode flags, one per regulation loop
            case (wr_cfg.mode)
                PLDPR_MODE_OFF: begin
                    next_state.closed_loop = 1'b0;
                    next_state.power_limit = 1'b0;
                end
                PLDPR_MODE_CLOSED: begin
                    next_state.closed_loop = 1'b1;
                    next_state.power_limit = 1'b0;
                end
                PLDPR_MODE_LIMIT: begin
                    next_state.closed_loop = 1'b0;
                    next_state.power_limit = 1'b1;
                end
                default: begin // reserved code must not run a loop, acts as disabled
                    next_state.closed_loop = 1'b0;
                    next_state.power_limit = 1'b0;
                end
            endcase
        end
        // every step shares one code table
        if (wr_two_hit) begin
            for (int s = 0; s < `PLDPR_STEP_COUNT; s++) begin
                next_state.duty[s] = pldpr_duty_of(wr_two.step[s]);
            end
        end
    end

    // answer register
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state.rsp.valid     <= 1'b0;
            state.rsp.data      <= 32'h0000_0000;
            // decodes start as those of an all-zero word
            state.hyst_half_pct <= `PLDPR_HYST_0;
            state.closed_loop   <= 1'b0;
            state.power_limit   <= 1'b0;
            state.duty          <= {`PLDPR_STEP_COUNT{`PLDPR_DUTY_0}};
        end else begin
            state <= next_state;
        end
    end

    // read answer leaves its own register
    assign rsp_o = state.rsp;

    // power regulation settings toward the algorithm
    assign max_speed_code_o            = pwr_cfg.max_speed;
    assign max_speed_hz_o              = pwr_cfg.max_speed[15:`PLDPR_SPEED_FRAC_BITS];
    assign dead_band_correction_on_o   = pwr_cfg.dead_band_correction_on;
    assign max_power_code_o            = pwr_cfg.max_power;
    assign max_power_w_o               = pwr_cfg.max_power[9:`PLDPR_POWER_FRAC_BITS];
    assign regulation_hysteresis_sel_o = pwr_cfg.regulation_hysteresis_sel;
    assign regulation_mode_o           = pwr_cfg.mode;

    // decoded settings straight from their flip-flops
    assign hysteresis_half_pct_o = state.hyst_half_pct;

    // reserved mode code 3 drives both mode flags low
    assign closed_loop_power_o = state.closed_loop;
    assign power_limit_o       = state.power_limit;

    // two-phase step fields and their duty
    assign two_phase_step_duty_first_o = two_ph.step[0];
    assign two_phase_step_duty_last_o  = two_ph.step[7];
    assign two_phase_duty_o            = state.duty;

    // three-phase word passed raw, its fields belong to the consumer
    assign three_phase_profile_o = three_word;

endmodule : pldpr_regs

// File: pldpr_regs_asserts.sv
`timescale 1ns/1ps
module pldpr_regs_asserts (
    input wire logic                  mclk_i,
    input wire logic                  rstn_i,
    input wire pldpr_pkg::pldpr_req_t req_i,
    input wire pldpr_pkg::pldpr_rsp_t rsp_o,
    input wire logic [15:0]           max_speed_code_o,
    input wire logic [11:0]           max_speed_hz_o,
    input wire logic                  dead_band_correction_on_o,
    input wire logic [9:0]            max_power_code_o,
    input wire logic [7:0]            max_power_w_o,
    input wire logic [1:0]            regulation_hysteresis_sel_o,
    input wire logic [4:0]            hysteresis_half_pct_o,
    input wire pldpr_pkg::pldpr_mode_t regulation_mode_o,
    input wire logic                  closed_loop_power_o,
    input wire logic                  power_limit_o,
    input wire logic [2:0]            two_phase_step_duty_first_o,
    input wire logic [2:0]            two_phase_step_duty_last_o,
    input wire logic [31:0]           three_phase_profile_o
);
    import pldpr_pkg::*;
    // one clock, one reset for all checks
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    a_read_answers: assert property (req_i.rd |=> rsp_o.valid)
        else $error("read not answered");
    a_no_stray_valid: assert property (!req_i.rd |=> !rsp_o.valid)
        else $error("answer without read");
    a_speed_hz: assert property (max_speed_hz_o == max_speed_code_o[15:4])
        else $error("speed hertz wrong");
    a_power_watts: assert property (max_power_w_o == max_power_code_o[9:2])
        else $error("power watts wrong");
    a_hyst_decode: assert property (hysteresis_half_pct_o ==
        5'(10 + 5 * regulation_hysteresis_sel_o)) else $error("hysteresis wrong");
    a_mode_decode: assert property ({closed_loop_power_o, power_limit_o} ==
        {regulation_mode_o == 2'h1, regulation_mode_o == 2'h2}) else $error("mode wrong");
    a_deadband_write: assert property (req_i.wr && req_i.addr == 8'h90 |=>
        dead_band_correction_on_o == $past(req_i.wdata[14])) else $error("deadband");
    a_step_write: assert property (req_i.wr && req_i.addr == 8'h96 |=>
        {two_phase_step_duty_first_o, two_phase_step_duty_last_o} ==
        {$past(req_i.wdata[30:28]), $past(req_i.wdata[9:7])}) else $error("steps");
    a_three_write: assert property (req_i.wr && req_i.addr == 8'h98 |=>
        three_phase_profile_o == $past(req_i.wdata)) else $error("three-phase");
    a_cfg_holds: assert property (!(req_i.wr && req_i.addr == 8'h90) |=>
        $stable(max_speed_code_o)) else $error("speed changed");
endmodule : pldpr_regs_asserts

bind pldpr_regs pldpr_regs_asserts u_chk (.mclk_i, .rstn_i, .req_i, .rsp_o,
    .max_speed_code_o, .max_speed_hz_o, .dead_band_correction_on_o, .max_power_code_o,
    .max_power_w_o, .regulation_hysteresis_sel_o, .hysteresis_half_pct_o,
    .regulation_mode_o, .closed_loop_power_o, .power_limit_o,
    .two_phase_step_duty_first_o, .two_phase_step_duty_last_o, .three_phase_profile_o);

// File: pldpr_regs_tb.sv
`timescale 1ns/1ps
module pldpr_regs_tb;
    import pldpr_pkg::*;
    logic mclk_i = 0, rstn_i = 0;
    pldpr_req_t req_i = '0;
    pldpr_rsp_t rsp_o;
    logic [15:0] max_speed_code_o;
    logic [11:0] max_speed_hz_o;
    logic [9:0] max_power_code_o;
    logic [7:0] max_power_w_o;
    logic [4:0] hysteresis_half_pct_o;
    logic [1:0] regulation_hysteresis_sel_o;
    logic [2:0] two_phase_step_duty_first_o, two_phase_step_duty_last_o;
    logic dead_band_correction_on_o, closed_loop_power_o, power_limit_o;
    pldpr_mode_t regulation_mode_o;
    pldpr_duty_vec_t two_phase_duty_o;
    logic [31:0] three_phase_profile_o, m_cfg = 0, m_two = 0, m_thr = 0, exp_d, d;
    int err_count = 0, num_checks = 0;
    int dt[8] = '{0, 200, 300, 335, 350, 375, 390, 396};
    pldpr_req_t q;
    pldpr_regs i_dut (.mclk_i, .rstn_i, .req_i, .rsp_o, .max_speed_code_o, .max_speed_hz_o,
        .dead_band_correction_on_o, .max_power_code_o, .max_power_w_o, .regulation_mode_o,
        .regulation_hysteresis_sel_o, .hysteresis_half_pct_o, .closed_loop_power_o,
        .power_limit_o, .two_phase_step_duty_first_o, .two_phase_step_duty_last_o,
        .two_phase_duty_o, .three_phase_profile_o);
    always #2.5 mclk_i = ~mclk_i;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (e !== g) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        req_i <= {w, r, a, v};
    endtask : op
    // model of the registers, compared with every output each cycle
    always @(posedge mclk_i) if (rstn_i) begin
        q = req_i;
        exp_d = !q.rd ? 0 : q.addr == 8'h90 ? m_cfg : q.addr == 8'h96 ? m_two :
                q.addr == 8'h98 ? m_thr : 0;
        if (q.wr && q.addr == 8'h90) m_cfg = q.wdata;
        if (q.wr && q.addr == 8'h96) m_two = q.wdata;
        if (q.wr && q.addr == 8'h98) m_thr = q.wdata;
        #1;
        chk("valid", q.rd, rsp_o.valid);
        chk("rdata", exp_d, rsp_o.data);
        chk("speed", m_cfg[30:15], max_speed_code_o);
        chk("hz", m_cfg[30:19], max_speed_hz_o);
        chk("deadband", m_cfg[14], dead_band_correction_on_o);
        chk("power", m_cfg[13:4], max_power_code_o);
        chk("watts", m_cfg[13:6], max_power_w_o);
        chk("hyst", 10 + 5 * m_cfg[3:2], hysteresis_half_pct_o);
        chk("hyst_sel", m_cfg[3:2], regulation_hysteresis_sel_o);
        chk("mode", m_cfg[1:0], regulation_mode_o);
        chk("closed", m_cfg[1:0] == 1, closed_loop_power_o);
        chk("limit", m_cfg[1:0] == 2, power_limit_o);
        chk("first", m_two[30:28], two_phase_step_duty_first_o);
        chk("last", m_two[9:7], two_phase_step_duty_last_o);
        for (int s = 0; s < 8; s++)
            chk("duty", dt[m_two[30-3*s -: 3]], two_phase_duty_o[s]);
        chk("three", m_thr, three_phase_profile_o);
    end
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    // reset, reset values, every mode and duty code, then random traffic
    initial begin
        void'($urandom(51672));
        repeat (8) @(posedge mclk_i);
        rstn_i <= 1;
        foreach (dt[i]) op(0, 1, 8'h90 + 8'(2 * i), 0);
        for (int m = 0; m < 4; m++) op(1, 1, 8'h90, {$urandom} & ~32'hf | 4'(m * 5));
        op(1, 1, 8'h96, 32'h829cbbff);
        op(1, 1, 8'h96, 32'h75315d00);
        for (int i = 0; i < 300; i++) begin
            d = $urandom;
            op(d[0], d[1], d[3] ? 8'h90 + 8'(d[5:4] * 4 + 2 * d[6]) : 8'(d[15:8]), $urandom);
        end
        op(0, 0, 0, 0);
        repeat (2) @(posedge mclk_i);
        results();
    end
endmodule : pldpr_regs_tb
